// >>> kts_defines.vh
// Constants for the kinetics trigger sequencer
`ifndef KTS_DEFINES_VH
`define KTS_DEFINES_VH
// Trigger response modes
`define KTS_TRIG_NONE 3'h0
`define KTS_TRIG_SINGLE 3'h1
`define KTS_TRIG_READOUT 3'h2
`define KTS_TRIG_SHIFT 3'h3
`define KTS_TRIG_PULSE 3'h4
// Shutter modes
`define KTS_SHUT_NORMAL 2'h0
`define KTS_SHUT_CLOSED 2'h1
`define KTS_SHUT_OPEN 2'h2
`define KTS_SHUT_BEFORE 2'h3
// Register offsets
`define KTS_REG_CTRL 4'h0
`define KTS_REG_EXPOSE 4'h4
`define KTS_REG_SHIFT 4'h8
`define KTS_REG_FRAMES 4'hc
`define KTS_REG_READOUT 4'h1
`define KTS_REG_OPEN_DLY 4'h2
`define KTS_REG_STATUS 4'h3
// Control fields
`define KTS_CTRL_TRIG_LSB 0
`define KTS_CTRL_SHUT_LSB 4
`define KTS_CTRL_FALL_BIT 8
`define KTS_CTRL_START_BIT 9
`define KTS_CTRL_ABORT_BIT 10
// Reset values
`define KTS_EXPOSE_RST 16'h0064
`define KTS_SHIFT_RST 16'h0010
`define KTS_FRAMES_RST 8'h03
`define KTS_READOUT_RST 16'h0100
`define KTS_OPEN_DLY_RST 16'h0020
`endif

// >>> kts_seq_sva.sv
// Port-level assertions for the kinetics trigger sequencer
`timescale 1ns/100ps
`default_nettype none
`include "kts_defines.vh"
module kts_seq_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic trig_in,
  input wire logic clean_until_trig,
  input wire logic shutter_open,
  input wire logic exposing,
  input wire logic shifting,
  input wire logic reading_out,
  input wire logic busy,
  input wire logic wait_trig
);
  logic [2:0] tm_q;
  logic [1:0] sm_q;
  logic fall_q;
  logic trig_q;
  wire idle = !busy && !wait_trig;
  wire ctl = reg_wr && reg_addr == `KTS_REG_CTRL && idle;
  wire go = ctl && reg_wdata[9];
  wire act = fall_q ? (trig_q && !trig_in) : (!trig_q && trig_in);
  wire inact = fall_q ? (!trig_q && trig_in) : (trig_q && !trig_in);
  // Mirror of the mode fields, since the checker sees only ports
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tm_q <= `KTS_TRIG_NONE;
      sm_q <= `KTS_SHUT_CLOSED;
      fall_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_in;
      if (ctl) begin
        tm_q <= reg_wdata[2:0];
        sm_q <= reg_wdata[5:4];
        fall_q <= reg_wdata[8];
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_DARK_SHUT: assert property (sm_q == `KTS_SHUT_CLOSED && $past(sm_q, 3) == `KTS_SHUT_CLOSED
    |-> !shutter_open) else $error("shutter opened in closed mode");
  AST_READ_SHUT: assert property (reading_out && sm_q != `KTS_SHUT_OPEN |-> !shutter_open)
    else $error("shutter open during readout");
  AST_OPEN_HOLD: assert property (sm_q == `KTS_SHUT_OPEN && (exposing || shifting)
    |-> shutter_open) else $error("always-open shutter closed");
  AST_SHIFT_SHUT: assert property (tm_q == `KTS_TRIG_SHIFT && sm_q == `KTS_SHUT_BEFORE
    && (wait_trig || shifting) |-> shutter_open) else $error("shutter shut within series");
  AST_SHIFT_TRIG: assert property (tm_q == `KTS_TRIG_SHIFT && wait_trig && act
    |-> ##[1:20] shifting) else $error("no shift after trigger");
  AST_PULSE_OPEN: assert property (tm_q == `KTS_TRIG_PULSE && wait_trig && act
    |-> ##[1:20] exposing) else $error("exposure missed leading edge");
  AST_PULSE_END: assert property (tm_q == `KTS_TRIG_PULSE && exposing && inact
    |-> ##[1:20] !exposing) else $error("exposure outlived pulse");
  AST_FREE_RUN: assert property (go && reg_wdata[2:0] inside {`KTS_TRIG_NONE, `KTS_TRIG_READOUT}
    |-> ##[1:3] (busy && !wait_trig)) else $error("free run did not start");
  AST_SINGLE_WAIT: assert property (go && reg_wdata[2:0] == `KTS_TRIG_SINGLE
    |-> ##[1:3] wait_trig) else $error("single mode not waiting");
  cover property (tm_q == `KTS_TRIG_PULSE && exposing);
  cover property (tm_q == `KTS_TRIG_SHIFT && shifting);
  cover property (reading_out && sm_q == `KTS_SHUT_CLOSED);
endmodule
`default_nettype wire

// >>> kts_sequencer.v
// Kinetics acquisition sequencer driven by an external trigger
// Function
// R01 - Single-trigger mode: one trigger runs all exposures, shifts and readout.
// R02 - Every triggered mode accepts normal, closed, open and open-before shutter modes.
// R03 - Readout-per-trigger mode: one trigger launches the whole frame series. Here the start write launches it and triggers are ignored.
// R04 - Readout-per-trigger: on start, open shutter and expose; then trigger arrives.
// R05 - Readout-per-trigger: after series, close shutter, read out, become ready.
// R06 - Shift-per-trigger: shutter opens at start, before any trigger.
// R07 - Shift-per-trigger: each exposure-shift cycle starts on its own trigger.
// R08 - Shift-per-trigger: after final cycle close shutter, read out, then ready.
// R09 - Shift-per-trigger: shutter stays open; exposure equals trigger spacing.
// R10 - Expose-during-pulse: shutter opens on leading trigger edge.
// R11 - Expose-during-pulse: shutter closes on trailing edge; exposure spans pulse.
// R12 - Outside party budgets shutter opening and closing delays in pulse mode.
// R13 - Outside party should avoid normal shutter mode with kinetics triggering.
// R14 - Clean-until-trigger adds variable latency from trigger to sequence.
// R15 - Always-open keeps shutter open, no opening wait; always-closed for darks.
// R16 - No-response mode ignores triggers and runs acquisitions on its own.
// R17 - Edge select chooses rising or falling; falling inverts pulse exposure.
// R18 - Triggers arriving while busy are discarded.
// R19 - Always-closed keeps shutter output low; sequencing otherwise unchanged. Here the opening wait is also skipped in this mode.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "kts_defines.vh"
module kts_sequencer #(
  parameter CNT_W = 16,
  parameter FRM_W = 8
) (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire trig_in,
  input wire clean_until_trig,
  output reg shutter_open,
  output reg exposing,
  output reg shifting,
  output reg reading_out,
  output reg busy,
  output reg wait_trig
);
  localparam ST_IDLE = 3'h0;
  localparam ST_OPEN = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_EXPOSE = 3'h3;
  localparam ST_SHIFT = 3'h4;
  localparam ST_READ = 3'h5;
  localparam ST_CLEAN = 3'h6;

  reg [2:0] trig_mode_q;
  reg [1:0] shut_mode_q;
  reg fall_sel_q;
  reg [CNT_W-1:0] expose_q;
  reg [CNT_W-1:0] shift_q;
  reg [FRM_W-1:0] frames_q;
  reg [CNT_W-1:0] readout_q;
  reg [CNT_W-1:0] open_dly_q;
  reg [2:0] state_q;
  reg [CNT_W-1:0] cnt_q;
  reg [FRM_W-1:0] frm_q;
  reg fired_q;
  reg clean_q;
  reg [3:0] jit_q;
  reg done_q;

  wire act_edge;
  wire inact_edge;
  wire trig_lvl;
  kts_trig_edge u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .trig_in(trig_in),
    .fall_sel(fall_sel_q),
    .active_edge(act_edge),
    .inactive_edge(inact_edge),
    .trig_level(trig_lvl)
  );

  wire wr_ctrl = reg_wr && (reg_addr == `KTS_REG_CTRL);
  wire start = wr_ctrl && reg_wdata[`KTS_CTRL_START_BIT] && (state_q == ST_IDLE);
  wire abort = wr_ctrl && reg_wdata[`KTS_CTRL_ABORT_BIT];
  wire last_frm = (frm_q == frames_q - {{(FRM_W-1){1'b0}}, 1'b1}) || (frames_q == {FRM_W{1'b0}});
  wire cnt_done = (cnt_q == {CNT_W{1'b0}});
  wire no_trig = (trig_mode_q == `KTS_TRIG_NONE);

  // Configuration is frozen while a series runs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_mode_q <= `KTS_TRIG_NONE;
      shut_mode_q <= `KTS_SHUT_CLOSED;
      fall_sel_q <= 1'b0;
      expose_q <= `KTS_EXPOSE_RST;
      shift_q <= `KTS_SHIFT_RST;
      frames_q <= `KTS_FRAMES_RST;
      readout_q <= `KTS_READOUT_RST;
      open_dly_q <= `KTS_OPEN_DLY_RST;
    end else if (reg_wr && state_q == ST_IDLE) begin
      case (reg_addr)
        `KTS_REG_CTRL: begin
          trig_mode_q <= reg_wdata[`KTS_CTRL_TRIG_LSB +: 3];
          shut_mode_q <= reg_wdata[`KTS_CTRL_SHUT_LSB +: 2]; // R02
          fall_sel_q <= reg_wdata[`KTS_CTRL_FALL_BIT]; // R17
        end
        `KTS_REG_EXPOSE: expose_q <= reg_wdata[CNT_W-1:0];
        `KTS_REG_SHIFT: shift_q <= reg_wdata[CNT_W-1:0];
        `KTS_REG_FRAMES: frames_q <= reg_wdata[FRM_W-1:0];
        `KTS_REG_READOUT: readout_q <= reg_wdata[CNT_W-1:0];
        `KTS_REG_OPEN_DLY: open_dly_q <= reg_wdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `KTS_REG_CTRL: reg_rdata <= {23'h000000, fall_sel_q, 2'h0, shut_mode_q, 1'b0, trig_mode_q};
        `KTS_REG_EXPOSE: reg_rdata <= {{(32-CNT_W){1'b0}}, expose_q};
        `KTS_REG_SHIFT: reg_rdata <= {{(32-CNT_W){1'b0}}, shift_q};
        `KTS_REG_FRAMES: reg_rdata <= {{(32-FRM_W){1'b0}}, frames_q};
        `KTS_REG_READOUT: reg_rdata <= {{(32-CNT_W){1'b0}}, readout_q};
        `KTS_REG_OPEN_DLY: reg_rdata <= {{(32-CNT_W){1'b0}}, open_dly_q};
        `KTS_REG_STATUS: reg_rdata <= {{(24-FRM_W){1'b0}}, frm_q, 3'h0, done_q, 1'b0, state_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Shutter needs an opening wait except always-open and always-closed
  wire need_open = (shut_mode_q == `KTS_SHUT_NORMAL) || (shut_mode_q == `KTS_SHUT_BEFORE); // R15
  wire [CNT_W-1:0] open_cnt = need_open ? open_dly_q : {CNT_W{1'b0}};

  // Main sequencer
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= {CNT_W{1'b0}};
      frm_q <= {FRM_W{1'b0}};
      fired_q <= 1'b0;
      clean_q <= 1'b0;
      jit_q <= 4'h0;
      done_q <= 1'b0;
    end else if (abort) begin
      state_q <= ST_IDLE;
      fired_q <= 1'b0;
    end else begin
      jit_q <= jit_q + 4'h1;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            done_q <= 1'b0;
            frm_q <= {FRM_W{1'b0}};
            fired_q <= 1'b0;
            clean_q <= clean_until_trig;
            // Pulse and single modes go to ST_WAIT at start; others open the shutter ahead of trigger
            if (trig_mode_q == `KTS_TRIG_PULSE || trig_mode_q == `KTS_TRIG_SINGLE) begin
              state_q <= ST_WAIT;
            end else begin
              state_q <= ST_OPEN; // R04 R06
              cnt_q <= open_cnt;
            end
          end
        end
        ST_OPEN: begin
          if (cnt_done) begin
            // A fired single trigger carries the whole series on its own
            if (no_trig || trig_mode_q == `KTS_TRIG_READOUT || fired_q) begin
              state_q <= ST_EXPOSE; // R16 R04 R01
              cnt_q <= expose_q;
            end else begin
              state_q <= ST_WAIT;
            end
          end else begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_WAIT: begin
          if (act_edge) begin
            // Cleaning is ended on a free-running phase, giving jitter
            if (clean_q) begin
              state_q <= ST_CLEAN; // R14
              cnt_q <= {{(CNT_W-4){1'b0}}, jit_q};
            end else if (trig_mode_q == `KTS_TRIG_PULSE) begin
              state_q <= ST_EXPOSE; // R10
            end else if (trig_mode_q == `KTS_TRIG_SINGLE) begin
              state_q <= ST_OPEN; // R01
              cnt_q <= open_cnt;
              fired_q <= 1'b1;
            end else begin
              state_q <= ST_SHIFT; // R07 R09
              cnt_q <= shift_q;
            end
          end
        end
        ST_CLEAN: begin
          if (cnt_done) begin
            clean_q <= 1'b0;
            if (trig_mode_q == `KTS_TRIG_PULSE) begin
              state_q <= trig_lvl ? ST_EXPOSE : ST_SHIFT;
              cnt_q <= shift_q;
            end else if (trig_mode_q == `KTS_TRIG_SHIFT) begin
              state_q <= ST_SHIFT;
              cnt_q <= shift_q;
            end else begin
              state_q <= ST_OPEN;
              cnt_q <= open_cnt;
              fired_q <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_EXPOSE: begin
          if (trig_mode_q == `KTS_TRIG_PULSE) begin
            if (inact_edge) begin
              state_q <= ST_SHIFT; // R11
              cnt_q <= shift_q;
            end
          end else if (cnt_done) begin
            state_q <= ST_SHIFT;
            cnt_q <= shift_q;
          end else begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_SHIFT: begin
          if (cnt_done) begin
            if (last_frm) begin
              state_q <= ST_READ; // R05 R08
              cnt_q <= readout_q;
            end else begin
              frm_q <= frm_q + {{(FRM_W-1){1'b0}}, 1'b1};
              // Only shift and pulse modes wait for a later trigger in a series; the others ignore later triggers
              if (trig_mode_q == `KTS_TRIG_SHIFT || trig_mode_q == `KTS_TRIG_PULSE) begin
                state_q <= ST_WAIT; // R07
              end else begin
                state_q <= ST_EXPOSE; // R01 R03
                cnt_q <= expose_q;
              end
            end
          end else begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_READ: begin
          if (cnt_done) begin
            state_q <= ST_IDLE; // R05 R08
            done_q <= 1'b1;
            fired_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Readout-per-trigger never enters ST_WAIT; the start write alone runs its whole series
  // Triggers outside ST_WAIT are ignored by construction
  wire ext_shut = (state_q == ST_OPEN) || (state_q == ST_EXPOSE) || (state_q == ST_SHIFT) ||
                  (state_q == ST_WAIT && (trig_mode_q == `KTS_TRIG_SHIFT ||
                   shut_mode_q == `KTS_SHUT_BEFORE)) ||
                  (state_q == ST_CLEAN && trig_mode_q == `KTS_TRIG_SHIFT); // R06 R09 R18

  // Outputs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shutter_open <= 1'b0;
      exposing <= 1'b0;
      shifting <= 1'b0;
      reading_out <= 1'b0;
      busy <= 1'b0;
      wait_trig <= 1'b0;
    end else begin
      case (shut_mode_q)
        `KTS_SHUT_CLOSED: shutter_open <= 1'b0; // R19
        `KTS_SHUT_OPEN: shutter_open <= 1'b1; // R15
        default: shutter_open <= ext_shut && (state_q != ST_READ) &&
                   !(trig_mode_q == `KTS_TRIG_PULSE && state_q == ST_SHIFT); // R10 R11
      endcase
      exposing <= (state_q == ST_EXPOSE);
      shifting <= (state_q == ST_SHIFT);
      reading_out <= (state_q == ST_READ);
      busy <= (state_q != ST_IDLE) && (state_q != ST_WAIT); // R18
      wait_trig <= (state_q == ST_WAIT);
    end
  end
endmodule
`default_nettype wire

// >>> kts_sequencer_test.sv
// Self-checking bench for the kinetics trigger sequencer
`timescale 1ns/100ps
`default_nettype none
`include "kts_defines.vh"
module kts_sequencer_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clean_until_trig = 1'b0;
  logic pulse_go = 1'b0;
  logic [15:0] pulse_len = 16'h0;
  logic idle_hi = 1'b0;
  logic sh_d = 1'b0;
  wire [31:0] reg_rdata;
  wire trig_in, shutter_open, exposing, shifting, reading_out, busy, wait_trig;
  int err_count = 0;
  int checks = 0;
  int shifts = 0;
  int open_rd = 0;
  int exps = 0;
  int opens = 0;
  logic [31:0] v;
  always #2 core_clk = ~core_clk;
  kts_sequencer dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .trig_in, .clean_until_trig, .shutter_open, .exposing, .shifting, .reading_out, .busy,
    .wait_trig);
  kts_trig_src src (.core_clk, .rst_n, .pulse_go, .pulse_len, .idle_hi, .trig_in);
  always @(posedge core_clk) begin
    sh_d <= shifting;
    if (shifting && !sh_d) shifts++;
    if (shutter_open && reading_out) open_rd++;
    if (exposing) exps++;
    if (shutter_open) opens++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data sampled inside its single valid cycle, clear of the edge
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic start(input logic [2:0] tm, input logic [1:0] sm, input logic f);
    wr(`KTS_REG_CTRL, {23'h0, f, 2'h0, sm, 1'b0, tm});
    wr(`KTS_REG_CTRL, {22'h0, 1'b1, f, 2'h0, sm, 1'b0, tm});
    repeat (3) @(posedge core_clk);
  endtask
  task automatic pulse(input logic [15:0] len);
    @(posedge core_clk);
    pulse_go <= 1'b1;
    pulse_len <= len;
    @(posedge core_clk);
    pulse_go <= 1'b0;
    repeat (len + 2) @(posedge core_clk);
  endtask
  task automatic wait_st(input logic want_wt);
    int i;
    for (i = 0; i < 3000 && (want_wt ? wait_trig !== 1'b1 : (busy !== 1'b0 || wait_trig !== 1'b0));
      i++) @(posedge core_clk);
    if (i == 3000) begin
      chk("state wait", 0, 1);
      final_report;
    end
  endtask
  task automatic t_regs;
    rd(`KTS_REG_EXPOSE, v);
    chk("expose reset", {16'h0, `KTS_EXPOSE_RST}, v);
    rd(`KTS_REG_FRAMES, v);
    chk("frames reset", {24'h0, `KTS_FRAMES_RST}, v);
    wr(`KTS_REG_EXPOSE, 32'h8);
    wr(`KTS_REG_SHIFT, 32'h4);
    wr(`KTS_REG_FRAMES, 32'h2);
    wr(`KTS_REG_READOUT, 32'ha);
    wr(`KTS_REG_OPEN_DLY, 32'h5);
    rd(`KTS_REG_EXPOSE, v);
    chk("expose", 32'h8, v);
    rd(4'h5, v);
    chk("unmapped", 32'h0, v);
    $display("regs done");
  endtask
  task automatic t_none;
    int s0 = shifts;
    int o0 = opens;
    start(`KTS_TRIG_NONE, `KTS_SHUT_CLOSED, 1'b0);
    pulse(16'h6);
    wait_st(1'b0);
    chk("none shifts", 2, shifts - s0);
    chk("dark shutter", 0, opens - o0);
    rd(`KTS_REG_STATUS, v);
    chk("none done", 1, v[4]);
    $display("none done");
  endtask
  task automatic t_single;
    int s0 = shifts;
    clean_until_trig <= 1'b1;
    start(`KTS_TRIG_SINGLE, `KTS_SHUT_OPEN, 1'b0);
    wait_st(1'b1);
    repeat (10) @(posedge core_clk);
    chk("single held", 0, shifts - s0);
    pulse(16'h4);
    wait_st(1'b0);
    chk("single shifts", 2, shifts - s0);
    clean_until_trig <= 1'b0;
    $display("single done");
  endtask
  task automatic t_readout;
    int s0 = shifts;
    int r0 = open_rd;
    start(`KTS_TRIG_READOUT, `KTS_SHUT_BEFORE, 1'b0);
    repeat (6) @(posedge core_clk);
    chk("readout open", 1, shutter_open);
    pulse(16'h3);
    wait_st(1'b0);
    chk("readout shifts", 2, shifts - s0);
    chk("readout shut", 0, open_rd - r0);
    pulse(16'h3);
    chk("late trigger", 0, busy);
    chk("late trigger wait", 0, wait_trig);
    $display("readout done");
  endtask
  task automatic t_shift;
    int s0 = shifts;
    int r0 = open_rd;
    start(`KTS_TRIG_SHIFT, `KTS_SHUT_BEFORE, 1'b0);
    wait_st(1'b1);
    chk("shift early open", 1, shutter_open);
    chk("shift idle", 0, shifts - s0);
    pulse(16'h3);
    wait_st(1'b1);
    chk("shift one", 1, shifts - s0);
    repeat (25) @(posedge core_clk);
    chk("shift gap open", 1, shutter_open);
    pulse(16'h3);
    wait_st(1'b0);
    chk("shift two", 2, shifts - s0);
    chk("shift read shut", 0, open_rd - r0);
    $display("shift done");
  endtask
  task automatic t_pulse;
    int e0;
    idle_hi <= 1'b1;
    start(`KTS_TRIG_PULSE, `KTS_SHUT_OPEN, 1'b1);
    repeat (2) begin
      wait_st(1'b1);
      e0 = exps;
      pulse(16'hc);
      chk("pulse width", 1, exps - e0 >= 11 && exps - e0 <= 13);
    end
    wait_st(1'b0);
    idle_hi <= 1'b0;
    $display("pulse done");
  endtask
  // Abort is honoured mid-series even though config writes are not
  task automatic t_abort;
    start(`KTS_TRIG_NONE, `KTS_SHUT_CLOSED, 1'b0);
    chk("abort busy", 1, busy);
    wr(`KTS_REG_CTRL, 32'h0000_0400);
    repeat (2) @(posedge core_clk);
    chk("abort idle", 0, busy);
    chk("abort exposing", 0, exposing);
    rd(`KTS_REG_STATUS, v);
    chk("abort status", 0, v[4:0]);
    $display("abort done");
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_none();
    t_single();
    t_readout();
    t_shift();
    t_pulse();
    t_abort();
    final_report();
  end
endmodule
bind kts_sequencer kts_seq_sva chk_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .trig_in(trig_in), .clean_until_trig(clean_until_trig), .shutter_open(shutter_open),
  .exposing(exposing), .shifting(shifting), .reading_out(reading_out), .busy(busy),
  .wait_trig(wait_trig));
`default_nettype wire

// >>> kts_trig_edge.v
// Trigger edge detector with selectable active polarity
`timescale 1ns/100ps
`default_nettype none
module kts_trig_edge (
  input wire core_clk,
  input wire rst_n,
  input wire trig_in,
  input wire fall_sel,
  output wire active_edge,
  output wire inactive_edge,
  output wire trig_level
);
  reg prev_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= trig_in;
    end
  end
  wire rise = trig_in & ~prev_q;
  wire fall = ~trig_in & prev_q;
  assign active_edge = fall_sel ? fall : rise; // R17
  assign inactive_edge = fall_sel ? rise : fall; // R17
  assign trig_level = fall_sel ? ~trig_in : trig_in;
endmodule
`default_nettype wire

// >>> kts_trig_src.sv
// Experiment trigger source facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module kts_trig_src (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pulse_go,
  input wire logic [15:0] pulse_len,
  input wire logic idle_hi,
  output wire logic trig_in
);
  logic [15:0] left_q;
  // Widths are chosen by the bench to cover shutter open and close delays
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      left_q <= 16'h0;
    else if (pulse_go)
      left_q <= pulse_len;
    else if (left_q != 16'h0)
      left_q <= left_q - 16'h1;
  end
  assign trig_in = idle_hi ^ (left_q != 16'h0);
endmodule
`default_nettype wire
